// ===== hdl/sre_shift_rotate_exec.sv
// shift and rotate execution datapath with machine-period sequencer and AXI4-Lite registers
`timescale 1ns/1ps
// Operation
// RL1: runs in fetch phase, IR loaded at T2
// RL2: group, op-zero, accumulator read strobes at T3
// RL3: word bits six-nine pick shift strobes
// RL4: rotate right uses right-mux and rotate strobes
// RL5: rotate right moves bit zero to fifteen
// RL6: sign-keep left shift drops old bit fourteen
// RL7: left shift clears bits fifteen and zero
// RL8: extend rotate inserts old extend at fifteen
// RL9: extend follows R-bus bit zero
// RL10: result stored back into same accumulator
// RL11: T6 increments PC, loads PC and MAR
// RL12: next phase one, or four on interrupt
// RL13: decode rotate right of A and B
// RL14: decode sign-keep left of A and B
// RL15: micro-ops at T3 and T5: read, shift, store
// RL16: T4 clears extend, tests lsb for skip
// RL17: loop switch suppresses PC increment carry
// RL18: accumulators and buses are 16-bit words
module sre_shift_rotate_exec #(
    parameter int TICK_DIV = sre_pkg::TICK_DIV_DEF,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // pins
    input wire logic loop_switch_i,
    input wire logic irq_pending_i,
    // strobes
    output logic shift_group_sel_o,
    output logic op_group_zero_o,
    output logic acc_a_to_rbus_o,
    output logic acc_b_to_rbus_o,
    output logic shift_right_mux_o,
    output logic rotate_right_sel_o,
    output logic shift_left_mux_o,
    output logic store_tbus_acc_a_o,
    output logic store_tbus_acc_b_o,
    output logic pc_to_rbus_o,
    output logic increment_carry_in_o,
    output logic adder_function_o,
    output logic store_pc_o,
    output logic store_mem_addr_o,
    // buses and state
    output logic [15:0] rbus_o,
    output logic [15:0] tbus_o,
    output logic [2:0] phase_o,
    output logic busy_o
);
    // the register map needs five address bits; the divider needs a nonzero count
    if (TICK_DIV < 1 || ADDR_W < 5)
    begin : g_param_check
        $error("sre: bad parameter");
    end

    sre_pkg::sre_period_t per_r;
    logic [15:0] tword_r, acc_a_r, acc_b_r, pc_r, mar_r, rbus_r, tbus_r;
    logic [5:0] ir_r;
    logic ext_r, skip_r, run_r, start_r, tick;
    logic [2:0] phase_r;
    logic [1:0] loop_sync_r, irq_sync_r;
    logic [$clog2(TICK_DIV+1)-1:0] div_r;

    function automatic logic reg_known(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        b = 8'(a);
        return b == sre_pkg::REG_CTRL || b == sre_pkg::REG_TWORD || b == sre_pkg::REG_ACC_A ||
               b == sre_pkg::REG_ACC_B || b == sre_pkg::REG_PC || b == sre_pkg::REG_MAR ||
               b == sre_pkg::REG_EXT || b == sre_pkg::REG_STATUS;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // {extend out, result}; unsupported codes leave the word unchanged
    function automatic logic [16:0] shift_op(input logic [2:0] code, input logic [15:0] v, input logic e);
        logic [16:0] r;
        r = {e, v};
        if (code == sre_pkg::OP_ROT_R)
        begin
            r = {e, v[0], v[15:1]}; // RL5
        end
        else if (code == sre_pkg::OP_KEEP_L)
        begin
            r = {e, 1'b0, v[13:0], 1'b0}; // RL6 RL7
        end
        else if (code == sre_pkg::OP_EXT_R)
        begin
            r = {v[0], e, v[15:1]}; // RL8 RL9
        end
        return r;
    endfunction

    // pins pass two flops before use
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            loop_sync_r <= 2'h0;
            irq_sync_r <= 2'h0;
        end
        else
        begin
            loop_sync_r <= {loop_sync_r[0], loop_switch_i};
            irq_sync_r <= {irq_sync_r[0], irq_pending_i};
        end
    end
    logic loop_s, irq_s;
    assign loop_s = loop_sync_r[1];
    assign irq_s = irq_sync_r[1];

    // axi write channel capture
    logic aw_full_r, w_full_r, bvalid_r, wr_fire, ar_fire, rvalid_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    assign s_axi_awready_o = !aw_full_r;
    assign s_axi_wready_o = !w_full_r;
    assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = !rvalid_r;
    assign ar_fire = s_axi_arvalid_i && !rvalid_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= sre_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_i && !aw_full_r)
            begin
                aw_full_r <= 1'b1;
                awaddr_r <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && !w_full_r)
            begin
                w_full_r <= 1'b1;
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end
            if (wr_fire)
            begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= reg_known(awaddr_r) ? sre_pkg::RESP_OKAY : sre_pkg::RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready_i)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    logic wr_ctrl, wr_tword, wr_a, wr_b, wr_pc, wr_ext;
    assign wr_ctrl = wr_fire && 8'(awaddr_r) == sre_pkg::REG_CTRL;
    assign wr_tword = wr_fire && 8'(awaddr_r) == sre_pkg::REG_TWORD;
    assign wr_a = wr_fire && 8'(awaddr_r) == sre_pkg::REG_ACC_A;
    assign wr_b = wr_fire && 8'(awaddr_r) == sre_pkg::REG_ACC_B;
    assign wr_pc = wr_fire && 8'(awaddr_r) == sre_pkg::REG_PC;
    assign wr_ext = wr_fire && 8'(awaddr_r) == sre_pkg::REG_EXT;

    // read channel
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= sre_pkg::RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= reg_known(s_axi_araddr_i) ? sre_pkg::RESP_OKAY : sre_pkg::RESP_SLVERR;
            if (8'(s_axi_araddr_i) == sre_pkg::REG_CTRL)
                rdata_r <= {30'h0, run_r, 1'b0};
            else if (8'(s_axi_araddr_i) == sre_pkg::REG_TWORD)
                rdata_r <= {16'h0000, tword_r};
            else if (8'(s_axi_araddr_i) == sre_pkg::REG_ACC_A)
                rdata_r <= {16'h0000, acc_a_r};
            else if (8'(s_axi_araddr_i) == sre_pkg::REG_ACC_B)
                rdata_r <= {16'h0000, acc_b_r};
            else if (8'(s_axi_araddr_i) == sre_pkg::REG_PC)
                rdata_r <= {16'h0000, pc_r};
            else if (8'(s_axi_araddr_i) == sre_pkg::REG_MAR)
                rdata_r <= {16'h0000, mar_r};
            else if (8'(s_axi_araddr_i) == sre_pkg::REG_EXT)
                rdata_r <= {31'h0, ext_r};
            else if (8'(s_axi_araddr_i) == sre_pkg::REG_STATUS)
                rdata_r <= {24'h0, ir_r[1:0], phase_r, skip_r, loop_s, busy_o};
            else
                rdata_r <= 32'h0000_0000;
        end
        else if (rvalid_r && s_axi_rready_i)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // period enable divider
    assign tick = (div_r == ($bits(div_r))'(TICK_DIV - 1));
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            div_r <= '0;
        else
            div_r <= tick ? '0 : div_r + 1'b1;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            run_r <= 1'b0;
            start_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && wstrb_r[0])
                run_r <= wdata_r[sre_pkg::CTRL_RUN];
            if (wr_ctrl && wstrb_r[0] && wdata_r[sre_pkg::CTRL_START])
                start_r <= 1'b1;
            else if (per_r == sre_pkg::PER_T0)
                start_r <= 1'b0;
        end
    end

    // machine period sequencer; idle between cycles unless running
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            per_r <= sre_pkg::PER_IDLE;
        else if (tick)
        begin
            case (per_r)
                sre_pkg::PER_IDLE: per_r <= (start_r || run_r) ? sre_pkg::PER_T0 : sre_pkg::PER_IDLE;
                sre_pkg::PER_T0: per_r <= sre_pkg::PER_T1;
                sre_pkg::PER_T1: per_r <= sre_pkg::PER_T2;
                sre_pkg::PER_T2: per_r <= sre_pkg::PER_T3;
                sre_pkg::PER_T3: per_r <= sre_pkg::PER_T4;
                sre_pkg::PER_T4: per_r <= sre_pkg::PER_T5;
                sre_pkg::PER_T5: per_r <= sre_pkg::PER_T6;
                sre_pkg::PER_T6: per_r <= sre_pkg::PER_T7;
                default: per_r <= run_r ? sre_pkg::PER_T0 : sre_pkg::PER_IDLE;
            endcase
        end
    end
    assign busy_o = per_r != sre_pkg::PER_IDLE;
    assign phase_o = phase_r;

    // decode
    logic in_fetch, group, sel_b, uop_en, uop_ok, t3, t4, t5, t6, skip_rd, pc_step;
    logic [2:0] code;
    logic [15:0] acc_rd, pc_sum;
    logic [16:0] shifted;
    assign in_fetch = phase_r == sre_pkg::PHASE_FETCH; // RL1
    assign group = in_fetch && ir_r[5:2] == sre_pkg::IR_GROUP_PAT && !ir_r[0]; // RL13 RL14
    assign sel_b = ir_r[sre_pkg::W_ACC_B - sre_pkg::IR_LSB];
    assign t3 = per_r == sre_pkg::PER_T3;
    assign t4 = per_r == sre_pkg::PER_T4;
    assign t5 = per_r == sre_pkg::PER_T5;
    assign t6 = per_r == sre_pkg::PER_T6;
    assign code = t3 ? tword_r[sre_pkg::W_CODE1_LSB +: 3] : tword_r[sre_pkg::W_CODE2_LSB +: 3]; // RL3
    assign uop_ok = code == sre_pkg::OP_ROT_R || code == sre_pkg::OP_KEEP_L || code == sre_pkg::OP_EXT_R;
    assign uop_en = group && uop_ok && ((t3 && tword_r[sre_pkg::W_EN1]) || (t5 && tword_r[sre_pkg::W_EN2])); // RL15
    assign skip_rd = group && t4 && tword_r[sre_pkg::W_SKIP];
    assign acc_rd = sel_b ? acc_b_r : acc_a_r; // RL18
    assign shifted = shift_op(code, acc_rd, ext_r);
    assign pc_step = t6 && tick;

    assign shift_group_sel_o = group && t3; // RL2
    assign op_group_zero_o = group && t3;
    assign acc_a_to_rbus_o = (group && t3 && !sel_b) || ((uop_en || skip_rd) && !sel_b);
    assign acc_b_to_rbus_o = (group && t3 && sel_b) || ((uop_en || skip_rd) && sel_b);
    assign shift_right_mux_o = uop_en && (code == sre_pkg::OP_ROT_R || code == sre_pkg::OP_EXT_R); // RL4
    assign rotate_right_sel_o = uop_en && code == sre_pkg::OP_ROT_R; // RL4
    assign shift_left_mux_o = uop_en && code == sre_pkg::OP_KEEP_L; // RL7
    assign store_tbus_acc_a_o = uop_en && !sel_b; // RL10
    assign store_tbus_acc_b_o = uop_en && sel_b; // RL10
    assign pc_to_rbus_o = t6 || per_r == sre_pkg::PER_T7;
    assign adder_function_o = pc_to_rbus_o;
    assign increment_carry_in_o = pc_to_rbus_o && !loop_s; // RL17
    assign store_pc_o = t6;
    assign store_mem_addr_o = t6;
    // skip carry adds a second step so the next word is passed over
    assign pc_sum = pc_r + {15'h0000, increment_carry_in_o} + {15'h0000, skip_r && !loop_s}; // RL11

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ir_r <= 6'h00;
        else if (tick && per_r == sre_pkg::PER_T2 && in_fetch)
            ir_r <= tword_r[15:sre_pkg::IR_LSB]; // RL1
    end

    // software writes lose to a hardware store in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            acc_a_r <= sre_pkg::WORD_RST;
            acc_b_r <= sre_pkg::WORD_RST;
            tword_r <= sre_pkg::WORD_RST;
        end
        else
        begin
            if (tick && store_tbus_acc_a_o)
                acc_a_r <= shifted[15:0]; // RL10
            else if (wr_a)
                acc_a_r <= merge16(acc_a_r, wdata_r, wstrb_r);
            if (tick && store_tbus_acc_b_o)
                acc_b_r <= shifted[15:0]; // RL10
            else if (wr_b)
                acc_b_r <= merge16(acc_b_r, wdata_r, wstrb_r);
            if (wr_tword)
                tword_r <= merge16(tword_r, wdata_r, wstrb_r);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ext_r <= 1'b0;
        else if (tick && uop_en && code == sre_pkg::OP_EXT_R)
            ext_r <= shifted[16]; // RL9
        else if (tick && group && t4 && tword_r[sre_pkg::W_CLE])
            ext_r <= 1'b0; // RL16
        else if (wr_ext && wstrb_r[0])
            ext_r <= wdata_r[0];
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            skip_r <= 1'b0;
        else if (tick && skip_rd && !acc_rd[0])
            skip_r <= 1'b1; // RL16
        else if (tick && per_r == sre_pkg::PER_T0)
            skip_r <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pc_r <= sre_pkg::WORD_RST;
            mar_r <= sre_pkg::WORD_RST;
            phase_r <= sre_pkg::PHASE_FETCH;
        end
        else
        begin
            if (pc_step)
            begin
                pc_r <= pc_sum; // RL11
                mar_r <= pc_sum;
            end
            else if (wr_pc)
            begin
                pc_r <= merge16(pc_r, wdata_r, wstrb_r);
            end
            if (tick && per_r == sre_pkg::PER_T7)
                phase_r <= irq_s ? sre_pkg::PHASE_INT : sre_pkg::PHASE_FETCH; // RL12
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rbus_r <= sre_pkg::WORD_RST;
            tbus_r <= sre_pkg::WORD_RST;
        end
        else if (uop_en || skip_rd)
        begin
            rbus_r <= acc_rd;
            tbus_r <= shifted[15:0];
        end
    end
    assign rbus_o = rbus_r;
    assign tbus_o = tbus_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_ir_load;
        tick && per_r == sre_pkg::PER_T2 && in_fetch |=> ir_r == $past(tword_r[15:10]);
    endproperty
    a_ir_load: assert property (p_ir_load) else $error("ir not loaded at T2"); // RL1
    property p_group_t3;
        t3 && group |-> shift_group_sel_o && op_group_zero_o && (acc_a_to_rbus_o != acc_b_to_rbus_o);
    endproperty
    a_group_t3: assert property (p_group_t3) else $error("group strobes missing at T3"); // RL2
    property p_rot_r;
        tick && uop_en && code == sre_pkg::OP_ROT_R && !sel_b |=> acc_a_r == {$past(acc_a_r[0]), $past(acc_a_r[15:1])};
    endproperty
    a_rot_r: assert property (p_rot_r) else $error("rotate right result wrong"); // RL5
    property p_keep_l;
        tick && uop_en && code == sre_pkg::OP_KEEP_L && sel_b |=> acc_b_r == {1'b0, $past(acc_b_r[13:0]), 1'b0};
    endproperty
    a_keep_l: assert property (p_keep_l) else $error("sign-keep left result wrong"); // RL6
    property p_ext_r;
        tick && uop_en && code == sre_pkg::OP_EXT_R |=> ext_r == $past(acc_rd[0]) && tbus_o[15] == $past(ext_r);
    endproperty
    a_ext_r: assert property (p_ext_r) else $error("extend rotate wrong"); // RL8
    property p_strobe_time;
        (store_tbus_acc_a_o || store_tbus_acc_b_o || shift_left_mux_o || shift_right_mux_o) |-> (t3 || t5);
    endproperty
    a_strobe_time: assert property (p_strobe_time) else $error("shift strobe outside T3/T5"); // RL15
    property p_pc_inc;
        pc_step && !loop_s && !skip_r |=> pc_r == $past(pc_r) + 16'h0001 && mar_r == pc_r;
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("pc increment wrong"); // RL11
    property p_phase;
        tick && per_r == sre_pkg::PER_T7 |=> phase_r == ($past(irq_s) ? sre_pkg::PHASE_INT : sre_pkg::PHASE_FETCH);
    endproperty
    a_phase: assert property (p_phase) else $error("next phase wrong"); // RL12
    property p_cle;
        tick && group && t4 && tword_r[sre_pkg::W_CLE] |=> !ext_r;
    endproperty
    a_cle: assert property (p_cle) else $error("extend not cleared"); // RL16
    property p_loop;
        loop_s |-> !increment_carry_in_o;
    endproperty
    a_loop: assert property (p_loop) else $error("carry not suppressed in loop"); // RL17
    c_rot_r: cover property (tick && rotate_right_sel_o);
    c_keep_l: cover property (tick && shift_left_mux_o);
    c_ext_r: cover property (tick && uop_en && code == sre_pkg::OP_EXT_R);
    c_int: cover property (tick && per_r == sre_pkg::PER_T7 && irq_s);
endmodule // sre_shift_rotate_exec

// ===== hdl/sre_pkg.sv
// shared constants for the shift and rotate execution block
package sre_pkg;
    localparam int WORD_W = 16;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TWORD = 8'h04;
    localparam logic [7:0] REG_ACC_A = 8'h08;
    localparam logic [7:0] REG_ACC_B = 8'h0C;
    localparam logic [7:0] REG_PC = 8'h10;
    localparam logic [7:0] REG_MAR = 8'h14;
    localparam logic [7:0] REG_EXT = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;
    // control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_RUN = 1;
    // instruction word fields
    localparam int IR_LSB = 10;
    localparam logic [3:0] IR_GROUP_PAT = 4'h0;
    localparam int W_ACC_B = 11;
    localparam int W_EN1 = 9;
    localparam int W_CODE1_LSB = 6;
    localparam int W_CLE = 5;
    localparam int W_EN2 = 4;
    localparam int W_SKIP = 3;
    localparam int W_CODE2_LSB = 0;
    // micro-operation codes
    localparam logic [2:0] OP_ROT_R = 3'h3;
    localparam logic [2:0] OP_KEEP_L = 3'h4;
    localparam logic [2:0] OP_EXT_R = 3'h5;
    // phases
    localparam logic [2:0] PHASE_FETCH = 3'h1;
    localparam logic [2:0] PHASE_INT = 3'h4;
    // reset values, response codes and default tick divider
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int TICK_DIV_DEF = 2;
    typedef enum logic [3:0] {PER_IDLE, PER_T0, PER_T1, PER_T2, PER_T3, PER_T4, PER_T5, PER_T6, PER_T7} sre_period_t;
endpackage

// ===== test/sre_timing_partner.sv
// model of the timing generator side: loop switch and interrupt request levels
`timescale 1ns/1ps
module sre_timing_partner (
    // clock
    input wire logic clk_i,
    // commanded levels
    input wire logic loop_req_i,
    input wire logic irq_req_i,
    // pins toward the block
    output logic loop_switch_o = 1'b0,
    output logic irq_pending_o = 1'b0
);
    // levels move just after an edge; the block must resynchronise them itself
    always @(posedge clk_i)
    begin
        loop_switch_o <= loop_req_i;
        irq_pending_o <= irq_req_i;
    end
endmodule // sre_timing_partner

// ===== test/sre_shift_rotate_exec_tb.sv
// self-checking testbench for the shift and rotate execution block
`timescale 1ns/1ps
module sre_shift_rotate_exec_tb;
    localparam logic [1:0] OK = sre_pkg::RESP_OKAY;
    localparam logic [7:0] A = sre_pkg::REG_ACC_A;
    localparam logic [7:0] B = sre_pkg::REG_ACC_B;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic loop_req = 1'b0;
    logic irq_req = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, loop_sw, irq_pin, busy_o;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] tbus;
    logic [2:0] phase_o;
    logic [33:0] expq[$];
    logic [31:0] r = 32'h0000_0052;
    int n_fail = 0;
    int n_compared = 0;
    int k;

    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    sre_timing_partner partner (.clk_i(clk_i), .loop_req_i(loop_req), .irq_req_i(irq_req),
        .loop_switch_o(loop_sw), .irq_pending_o(irq_pin));

    // bready, rready and wstrb are held constant: always ready, full words
    sre_shift_rotate_exec #(.TICK_DIV(2), .ADDR_W(8)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1),
        .loop_switch_i(loop_sw), .irq_pending_i(irq_pin),
        .shift_group_sel_o(), .op_group_zero_o(), .acc_a_to_rbus_o(), .acc_b_to_rbus_o(),
        .shift_right_mux_o(), .rotate_right_sel_o(), .shift_left_mux_o(), .store_tbus_acc_a_o(),
        .store_tbus_acc_b_o(), .pc_to_rbus_o(), .increment_carry_in_o(), .adder_function_o(),
        .store_pc_o(), .store_mem_addr_o(), .rbus_o(), .tbus_o(tbus), .phase_o(phase_o), .busy_o(busy_o));

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // sampling at the falling edge sees what the next rising edge will take
    always @(negedge clk_i)
    begin
        if (rvalid)
            chk("rdata", {rresp, rdata}, expq.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        int i;
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(negedge clk_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge clk_i);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            if (tb)
            begin
                chk("bresp", {32'h0000_0000, bresp}, {32'h0000_0000, er});
                return;
            end
        end
        n_fail++;
        test_done();
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [15:0] d);
        logic ta, tr;
        int i;
        expq.push_back({er, 16'h0000, d});
        araddr <= a;
        arvalid <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(negedge clk_i);
            ta = arvalid && arready;
            tr = rvalid;
            @(posedge clk_i);
            if (ta)
                arvalid <= 1'b0;
            if (tr)
                return;
        end
        n_fail++;
        test_done();
    endtask

    task automatic wait_run();
        logic seen;
        int i;
        seen = 1'b0;
        for (i = 0; i < 400; i++)
        begin
            @(negedge clk_i);
            if (seen && !busy_o)
                break;
            seen = seen || busy_o;
        end
        @(posedge clk_i);
        if (i == 400)
        begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic run(input logic [7:0] a, input logic [15:0] tw, input logic [15:0] v, input logic e,
                       input logic [15:0] x, input logic ex);
        wr(a, v, OK);
        wr(sre_pkg::REG_EXT, {15'h0000, e}, OK);
        wr(sre_pkg::REG_TWORD, tw, OK);
        wr(sre_pkg::REG_CTRL, 16'h0001, OK);
        wait_run();
        // the T-bus keeps the last shifted word; words with no micro-op or skip test leave it stale
        if (x != v)
            chk("tbus", {18'h0_0000, tbus}, {18'h0_0000, x});
        rd(a, OK, x);
        rd(sre_pkg::REG_EXT, OK, {15'h0000, ex});
    endtask

    initial
    begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rd(A, OK, sre_pkg::WORD_RST);
        chk("phase", {31'h0000_0000, phase_o}, {31'h0000_0000, sre_pkg::PHASE_FETCH});
        loop_req <= 1'b1;
        wr(sre_pkg::REG_PC, 16'h0040, OK);
        run(A, 16'h02C0, 16'h5555, 1'b0, 16'hAAAA, 1'b0);
        run(B, 16'h0AC0, 16'h0001, 1'b0, 16'h8000, 1'b0);
        run(A, 16'h0300, 16'hD555, 1'b1, 16'h2AAA, 1'b1);
        run(B, 16'h0B00, 16'hFFFF, 1'b0, 16'h7FFE, 1'b0);
        run(A, 16'h0340, 16'h5555, 1'b0, 16'h2AAA, 1'b1);
        run(A, 16'h0340, 16'h2AAA, 1'b1, 16'h9555, 1'b0);
        run(B, 16'h0B40, 16'h8000, 1'b1, 16'hC000, 1'b0);
        run(A, 16'h0360, 16'h0001, 1'b0, 16'h0000, 1'b0);
        run(A, 16'h02D3, 16'h0003, 1'b0, 16'hC000, 1'b0);
        run(A, 16'h42C0, 16'h1234, 1'b0, 16'h1234, 1'b0);
        for (k = 0; k < 4; k++)
        begin
            r = xs(r);
            run(A, 16'h02C0, r[15:0], 1'b0, {r[0], r[15:1]}, 1'b0);
        end
        rd(sre_pkg::REG_PC, OK, 16'h0040);
        loop_req <= 1'b0;
        irq_req <= 1'b1;
        run(A, 16'h0008, 16'h0002, 1'b0, 16'h0002, 1'b0);
        rd(sre_pkg::REG_PC, OK, 16'h0042);
        rd(sre_pkg::REG_MAR, OK, 16'h0042);
        chk("phase", {31'h0000_0000, phase_o}, {31'h0000_0000, sre_pkg::PHASE_INT});
        irq_req <= 1'b0;
        // interrupt phase: the word is not executed, only PC and MAR step
        run(A, 16'h02C0, 16'h0001, 1'b0, 16'h0001, 1'b0);
        rd(sre_pkg::REG_PC, OK, 16'h0043);
        chk("phase", {31'h0000_0000, phase_o}, {31'h0000_0000, sre_pkg::PHASE_FETCH});
        // a read-only place and an unmapped one
        wr(sre_pkg::REG_MAR, 16'hFFFF, OK);
        rd(sre_pkg::REG_MAR, OK, 16'h0043);
        wr(8'h20, 16'h1234, sre_pkg::RESP_SLVERR);
        rd(8'h20, sre_pkg::RESP_SLVERR, 16'h0000);
        // free running, then stopped: the sequencer ends its cycle and idles
        wr(sre_pkg::REG_CTRL, 16'h0002, OK);
        rd(sre_pkg::REG_CTRL, OK, 16'h0002);
        wr(sre_pkg::REG_CTRL, 16'h0000, OK);
        repeat (20) @(posedge clk_i);
        rd(sre_pkg::REG_STATUS, OK, {10'h000, sre_pkg::PHASE_FETCH, 3'h0});
        repeat (2) @(posedge clk_i);
        test_done();
    end
endmodule // sre_shift_rotate_exec_tb
